// ### logic/gpio_pin_map.vh
// Register offsets, field positions, reset values and timing counts of the pin support block.
`ifndef GPIO_PIN_MAP_VH
`define GPIO_PIN_MAP_VH

`define OFS_UTIL_CFG       12'h80A
`define OFS_PIN_ROUTE      12'h80C
`define OFS_DEB_PERIOD     12'h80D
`define OFS_IRQ_STATUS     12'h810
`define OFS_IRQ_ENABLE     12'h814
`define OFS_RISE_MASK      12'h824
`define OFS_FALL_MASK      12'h828
`define OFS_FILT_SEL_A     12'h840
`define OFS_FILT_SEL_B     12'h841

`define UCFG_SPI_OFF       2
`define UCFG_UART_ON       1
`define ROUTE_LED_SRC      7
`define ROUTE_CARD2_REL    6
`define ROUTE_CARD2_HI_REL 5
`define ROUTE_SCARD_REL    4

`define RST_UTIL_CFG       8'h00
`define RST_PIN_ROUTE      8'h00
`define RST_DEB_PERIOD     8'h0A
`define RST_MASK           32'hFFFFFFFF
`define RST_FILT_SEL       8'h00
`define UCFG_RW_BITS       8'h06
`define FSB_RW_BITS        8'h01

`define MEDIA_SEL_CARD     4'h8
`define DEB_STEP_MS        10
`define CLK_MHZ            100
`define DEB_STEP_CYCLES    (`DEB_STEP_MS * `CLK_MHZ * 1000)

`endif

// ### logic/gpio_irq_debounce_pinmux.v
// Pin edge interrupts, input debounce filter and shared pin routing for the pin support block.
// Function
// - Rising pin edge raises an interrupt when its rise mask bit is zero.
// - Falling pin edge raises an interrupt when its fall mask bit is zero.
// - Rise mask: 32 read-write bits, reset all ones, one suppresses.
// - Fall mask: 32 read-write bits, reset all ones, one suppresses.
// - Filter select A bits 7..2 enable filtering of pins 15,14,13,12,5,3 as inputs.
// - Filter select B bit 0 filters pin 16; bits 7..1 read zero.
// - Debounce period eight bits, 10 ms per count, resets to 100 ms.
// - Filtered input passes first transition, suppresses others within the period.
// - SPI stays enabled after reset until firmware sets the disable bit.
// - Utility bit 1 routes UART transmit and receive to pins 11 and 12.
// - Route bit 7 picks LED source: pin 0 logic or smart card activity.
// - Route bit 6 releases pins 17 to 26 from the second card.
// - Pin 16 is a general-purpose pin from the first clock after reset.
// - Route bit 5 releases pins 22 to 25 unless bit 6 is set.
// - Route bit 4 releases pins 27 to 31 from the smart card.
// - Media select field 3:0 picks flash media; 1000 is the card.
`include "gpio_pin_map.vh"
module gpio_irq_debounce_pinmux #(
   parameter NPIN       = 32,
   parameter STEP_COUNT = `DEB_STEP_CYCLES
) (
   input  wire            clk,
   input  wire            rst_n,
   input  wire [11:0]     addr,
   input  wire [31:0]     wdata,
   input  wire            wr,
   input  wire            rd,
   output reg  [31:0]     rdata,
   input  wire [NPIN-1:0] pin_in,
   input  wire [NPIN-1:0] pin_is_input,
   output reg  [NPIN-1:0] edge_irq,
   output reg             irq,
   input  wire            led0_logic,
   input  wire            scard_led,
   output reg             led_pin,
   output reg             spi_enable,
   output reg             uart_on_pins,
   output reg  [NPIN-1:0] pin_is_gpio,
   output reg  [3:0]      media_select,
   output reg             media_is_card
);

   // Width of the step counter; sized from the step length so no clock rate can wrap it.
   function integer count_bits;
      input integer value;
      integer       v;
      begin
         count_bits = 1;
         v = value;
         while (v > 1) begin
            count_bits = count_bits + 1;
            v = v >> 1;
         end
      end
   endfunction

   localparam CW = count_bits(STEP_COUNT);

   ////////////////////////////////////////////////////////////////////////////
   // Software visible registers.
   reg [7:0]      util_q;
   reg [7:0]      route_q;
   reg [7:0]      period_q;
   reg [31:0]     rise_mask_bits_q;
   reg [31:0]     fall_mask_bits_q;
   reg [7:0]      filt_a_q;
   reg [7:0]      filt_b_q;
   reg [31:0]     status_q;
   reg [31:0]     enable_q;

   // Pin path: two synchroniser stages, the filtered level and its last value.
   reg [NPIN-1:0] sync1_q;
   reg [NPIN-1:0] sync2_q;
   reg [NPIN-1:0] clean_q;
   reg [NPIN-1:0] prev_q;
   reg [NPIN-1:0] hold_q;
   reg [7:0]      hold_cnt_q [0:NPIN-1];

   // Debounce timer: one shared step pulse for all filtered pins.
   reg [CW-1:0]   step_cnt_q;
   reg            step_q;

   // Combinational next values.
   reg [NPIN-1:0] filt_en;
   reg [NPIN-1:0] rise_d;
   reg [NPIN-1:0] fall_d;
   reg [NPIN-1:0] edge_d;
   reg [NPIN-1:0] gpio_d;
   reg [31:0]     rdata_d;
   integer        i;

   function hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // Byte-wide registers read back in the low byte of the word.
   function [31:0] widen8;
      input [7:0] value;
      begin
         widen8 = {24'h000000, value};
      end
   endfunction

   // One decoded write select per register.
   wire           wr_util   = wr && hit(addr, `OFS_UTIL_CFG);
   wire           wr_route  = wr && hit(addr, `OFS_PIN_ROUTE);
   wire           wr_period = wr && hit(addr, `OFS_DEB_PERIOD);
   wire           wr_rise   = wr && hit(addr, `OFS_RISE_MASK);
   wire           wr_fall   = wr && hit(addr, `OFS_FALL_MASK);
   wire           wr_filt_a = wr && hit(addr, `OFS_FILT_SEL_A);
   wire           wr_filt_b = wr && hit(addr, `OFS_FILT_SEL_B);
   wire           wr_status = wr && hit(addr, `OFS_IRQ_STATUS);
   wire           wr_enable = wr && hit(addr, `OFS_IRQ_ENABLE);

   // Only pins wired to a filter can be debounced; the rest are never slowed down.
   always @* begin
      filt_en = {NPIN{1'b0}};
      filt_en[15] = filt_a_q[7];
      filt_en[14] = filt_a_q[6];
      filt_en[13] = filt_a_q[5];
      filt_en[12] = filt_a_q[4];
      filt_en[5]  = filt_a_q[3];
      filt_en[3]  = filt_a_q[2];
      filt_en[16] = filt_b_q[0];
      filt_en = filt_en & pin_is_input;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared 10 ms step; each filtered pin counts steps after its last accepted edge.
   always @(posedge clk) begin
      if (!rst_n) begin
         step_cnt_q <= {CW{1'b0}};
         step_q <= 1'b0;
      end else if (step_cnt_q == STEP_COUNT - 1) begin
         step_cnt_q <= {CW{1'b0}};
         step_q <= 1'b1;
      end else begin
         step_cnt_q <= step_cnt_q + {{(CW-1){1'b0}}, 1'b1};
         step_q <= 1'b0;
      end
   end

   // Two stages before the edge logic; only the second stage is read downstream.
   always @(posedge clk) begin
      if (!rst_n) begin
         sync1_q <= {NPIN{1'b0}};
         sync2_q <= {NPIN{1'b0}};
         prev_q <= {NPIN{1'b0}};
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q <= clean_q;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         clean_q <= {NPIN{1'b0}};
         hold_q <= {NPIN{1'b0}};
         for (i = 0; i < NPIN; i = i + 1)
            hold_cnt_q[i] <= 8'h00;
      end else begin
         for (i = 0; i < NPIN; i = i + 1) begin
            // Leaving input mode drops any hold, so the next filtered edge passes at once.
            if (!filt_en[i]) begin
               clean_q[i] <= sync2_q[i];
               hold_q[i] <= 1'b0;
            end else if (hold_q[i]) begin
               // The step may land anywhere in the first interval, so the window
               // is up to one step shorter than the period; a trade for one timer.
               if (step_q) begin
                  if (hold_cnt_q[i] <= 8'h01)
                     hold_q[i] <= 1'b0;
                  else
                     hold_cnt_q[i] <= hold_cnt_q[i] - 8'h01;
               end
            end else if (sync2_q[i] != clean_q[i]) begin
               clean_q[i] <= sync2_q[i];
               hold_q[i] <= (period_q != 8'h00);
               hold_cnt_q[i] <= period_q;
            end
         end
      end
   end

   always @* begin
      rise_d = clean_q & ~prev_q & ~rise_mask_bits_q[NPIN-1:0];
      fall_d = ~clean_q & prev_q & ~fall_mask_bits_q[NPIN-1:0];
      edge_d = rise_d | fall_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (!rst_n) begin
         util_q <= `RST_UTIL_CFG;
         route_q <= `RST_PIN_ROUTE;
         period_q <= `RST_DEB_PERIOD;
         rise_mask_bits_q <= `RST_MASK;
         fall_mask_bits_q <= `RST_MASK;
         filt_a_q <= `RST_FILT_SEL;
         filt_b_q <= `RST_FILT_SEL;
         enable_q <= 32'h00000000;
      end else begin
         // Reserved bits are stored as zero, so reads need no masking.
         if (wr_util)
            util_q <= wdata[7:0] & `UCFG_RW_BITS;
         if (wr_route)
            route_q <= wdata[7:0];
         if (wr_period)
            period_q <= wdata[7:0];
         if (wr_rise)
            rise_mask_bits_q <= wdata;
         if (wr_fall)
            fall_mask_bits_q <= wdata;
         if (wr_filt_a)
            filt_a_q <= {wdata[7:2], 2'b00};
         if (wr_filt_b)
            filt_b_q <= wdata[7:0] & `FSB_RW_BITS;
         if (wr_enable)
            enable_q <= wdata;
      end
   end

   // A new edge in the cycle of a write-one-to-clear keeps its status bit set.
   always @(posedge clk) begin
      if (!rst_n)
         status_q <= 32'h00000000;
      else if (wr_status)
         status_q <= (status_q & ~wdata) | edge_d;
      else
         status_q <= status_q | edge_d;
   end

   always @* begin
      rdata_d = 32'h00000000;
      if (rd) begin
         if (hit(addr, `OFS_UTIL_CFG))
            rdata_d = widen8(util_q);
         else if (hit(addr, `OFS_PIN_ROUTE))
            rdata_d = widen8(route_q);
         else if (hit(addr, `OFS_DEB_PERIOD))
            rdata_d = widen8(period_q);
         else if (hit(addr, `OFS_RISE_MASK))
            rdata_d = rise_mask_bits_q;
         else if (hit(addr, `OFS_FALL_MASK))
            rdata_d = fall_mask_bits_q;
         else if (hit(addr, `OFS_FILT_SEL_A))
            rdata_d = widen8(filt_a_q);
         else if (hit(addr, `OFS_FILT_SEL_B))
            rdata_d = widen8(filt_b_q);
         else if (hit(addr, `OFS_IRQ_STATUS))
            rdata_d = status_q;
         else if (hit(addr, `OFS_IRQ_ENABLE))
            rdata_d = enable_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always @* begin
      gpio_d = {NPIN{1'b1}};
      if (!util_q[`UCFG_SPI_OFF]) begin
         gpio_d[2] = 1'b0;
         gpio_d[4] = 1'b0;
         gpio_d[5] = 1'b0;
      end
      if (util_q[`UCFG_UART_ON]) begin
         gpio_d[11] = 1'b0;
         gpio_d[12] = 1'b0;
      end
      if (!route_q[`ROUTE_CARD2_REL]) begin
         gpio_d[17] = 1'b0;
         gpio_d[18] = 1'b0;
         gpio_d[19] = 1'b0;
         gpio_d[20] = 1'b0;
         gpio_d[21] = 1'b0;
         gpio_d[22] = 1'b0;
         gpio_d[23] = 1'b0;
         gpio_d[24] = 1'b0;
         gpio_d[25] = 1'b0;
         gpio_d[26] = 1'b0;
      end
      // Releasing the upper lines alone leaves the card pins 17 to 21 and 26, a six-line bus.
      if (route_q[`ROUTE_CARD2_HI_REL]) begin
         gpio_d[22] = 1'b1;
         gpio_d[23] = 1'b1;
         gpio_d[24] = 1'b1;
         gpio_d[25] = 1'b1;
      end
      if (!route_q[`ROUTE_SCARD_REL]) begin
         gpio_d[27] = 1'b0;
         gpio_d[28] = 1'b0;
         gpio_d[29] = 1'b0;
         gpio_d[30] = 1'b0;
         gpio_d[31] = 1'b0;
      end
      gpio_d[16] = 1'b1;
   end

   // Read data stand for the one cycle after the strobe and are zero otherwise.
   always @(posedge clk) begin
      if (!rst_n)
         rdata <= 32'h00000000;
      else
         rdata <= rdata_d;
   end

   // The level output lags status by one cycle so that it stays a plain flop output.
   always @(posedge clk) begin
      if (!rst_n) begin
         edge_irq <= {NPIN{1'b0}};
         irq <= 1'b0;
      end else begin
         edge_irq <= edge_d;
         irq <= |(status_q & enable_q);
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         led_pin <= 1'b0;
         spi_enable <= 1'b1;
         uart_on_pins <= 1'b0;
         pin_is_gpio <= {NPIN{1'b0}};
         media_select <= 4'h0;
         media_is_card <= 1'b0;
      end else begin
         led_pin <= route_q[`ROUTE_LED_SRC] ? scard_led : led0_logic;
         spi_enable <= !util_q[`UCFG_SPI_OFF];
         uart_on_pins <= util_q[`UCFG_UART_ON];
         pin_is_gpio <= gpio_d;
         media_select <= route_q[3:0];
         media_is_card <= (route_q[3:0] == `MEDIA_SEL_CARD);
      end
   end

endmodule

// ### tb/gpio_pin_checker_assertions.sv
// Concurrent checks on the pin support block ports.
module gpio_pin_checker #(
   parameter NPIN = 32
) (
   input wire            clk,
   input wire            rst_n,
   input wire [11:0]     addr,
   input wire            wr,
   input wire [NPIN-1:0] pin_in,
   input wire [NPIN-1:0] edge_irq,
   input wire            irq,
   input wire            spi_enable,
   input wire            uart_on_pins,
   input wire [NPIN-1:0] pin_is_gpio,
   input wire [3:0]      media_select,
   input wire            media_is_card
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire ucfg_w = wr && addr == 12'h80A;
   // The pin must have settled a few cycles before the pulse, so a pulse with no cause shows.
   edge_cause_a: assert property (edge_irq[0] |-> $past(pin_in[0], 2) != $past(pin_in[0], 6))
      else $error("pulse without pin change");
   irq_cause_a: assert property ($rose(irq) |-> $past(wr, 2) || |$past(edge_irq))
      else $error("irq rose without cause");
   spi_drop_a: assert property ($fell(spi_enable) |-> $past(ucfg_w) || $past(ucfg_w, 2))
      else $error("spi dropped without write");
   uart_move_a: assert property ($changed(uart_on_pins) |-> $past(ucfg_w) || $past(ucfg_w, 2))
      else $error("uart route moved without write");
   pin16_gpio_a: assert property ($past(rst_n) |-> pin_is_gpio[16])
      else $error("pin 16 not general purpose");
   card2_group_a: assert property (pin_is_gpio[17] == pin_is_gpio[26])
      else $error("second card group split");
   card2_upper_a: assert property (pin_is_gpio[17] |-> pin_is_gpio[25:22] == 4'hF)
      else $error("upper data lines not released");
   media_card_a: assert property (media_is_card == (media_select == 4'h8))
      else $error("media card flag wrong");
endmodule
bind gpio_irq_debounce_pinmux gpio_pin_checker #(.NPIN(NPIN)) chk (.clk(clk), .rst_n(rst_n),
   .addr(addr), .wr(wr), .pin_in(pin_in), .edge_irq(edge_irq), .irq(irq),
   .spi_enable(spi_enable), .uart_on_pins(uart_on_pins), .pin_is_gpio(pin_is_gpio),
   .media_select(media_select), .media_is_card(media_is_card));

// ### tb/pin_world.sv
// External pins and an interrupt controller that counts edge pulses.
module pin_world (
   input  wire         clk,
   input  wire  [31:0] level,
   input  wire  [31:0] edge_irq,
   output logic [31:0] pin_in,
   output int unsigned pulses
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pin_in = 32'h0;
   // Pins move only after a clock edge, so the synchroniser sees clean levels.
   always @(posedge clk) begin
      pin_in <= level;
      pulses <= pulses + $countones(edge_irq);
   end
endmodule

// ### tb/gpio_irq_debounce_pinmux_tb.sv
// Self-checking bench for the pin support block.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module gpio_irq_debounce_pinmux_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [11:0] a; logic [31:0] w, r0, r1;} row_t;
   row_t rows [8] = '{'{12'h80A, 32'hFF, 32'h0, 32'h6}, '{12'h80C, 32'h5A, 32'h0, 32'h5A},
      '{12'h80D, 32'h5, 32'hA, 32'h5}, '{12'h824, 32'h12345678, '1, 32'h12345678},
      '{12'h828, 32'hA5A5A5A5, '1, 32'hA5A5A5A5}, '{12'h840, 32'hFF, 32'h0, 32'hFC},
      '{12'h841, 32'hFF, 32'h0, 32'h1}, '{12'h900, 32'hFF, 32'h0, 32'h0}};
   logic        clk = 0, rst_n = 0, wr = 0, rd = 0, led0_logic = 0, scard_led = 0;
   logic [11:0] addr = 0;
   logic [31:0] wdata = 0, pin_is_input = 0, lvl = 0, d;
   wire  [31:0] rdata, pin_in, edge_irq, pin_is_gpio;
   wire         irq, led_pin, spi_enable, uart_on_pins, media_is_card;
   wire  [3:0]  media_select;
   int          num_errors = 0, comparisons = 0;
   int unsigned pulses;
   initial forever #5 clk = ~clk;
   gpio_irq_debounce_pinmux #(.STEP_COUNT(10)) dut (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
      .pin_is_input(pin_is_input), .edge_irq(edge_irq), .irq(irq), .led0_logic(led0_logic),
      .scard_led(scard_led), .led_pin(led_pin), .spi_enable(spi_enable),
      .uart_on_pins(uart_on_pins), .pin_is_gpio(pin_is_gpio), .media_select(media_select),
      .media_is_card(media_is_card));
   pin_world far (.clk(clk), .level(lvl), .edge_irq(edge_irq), .pin_in(pin_in), .pulses(pulses));
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wreg(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
   task rreg(input logic [11:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task do_reset;
      rst_n <= 1'b0;
      tick(4);
      rst_n <= 1'b1;
   endtask
   task give_verdict;
      if (num_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      do_reset;
      tick(2);
      `CHK(pin_is_gpio, 32'h0001FFCB)
      `CHK(spi_enable, 1'b1)
      foreach (rows[i]) begin
         rreg(rows[i].a);
         `CHK(d, rows[i].r0)
         wreg(rows[i].a, rows[i].w);
         rreg(rows[i].a);
         `CHK(d, rows[i].r1)
      end
      `CHK(pin_is_gpio, 32'hFFFFE7FF)
      `CHK(uart_on_pins, 1'b1)
      `CHK(spi_enable, 1'b0)
      led0_logic <= 1'b1;
      wreg(12'h80C, 32'hA8);
      tick(3);
      `CHK(led_pin, 1'b0)
      `CHK(pin_is_gpio, 32'h03C1E7FF)
      `CHK(media_is_card, 1'b1)
      `CHK(media_select, 4'h8)
      do_reset;
      wreg(12'h824, 32'hFFFFFFFE);
      `CHK(led_pin, 1'b1)
      wreg(12'h814, 32'h1);
      lvl[0] <= 1'b1;
      tick(8);
      `CHK(pulses, 1)
      `CHK(irq, 1'b1)
      wreg(12'h810, 32'h1);
      lvl[0] <= 1'b0;
      tick(8);
      `CHK(irq, 1'b0)
      `CHK(pulses, 1)
      wreg(12'h828, 32'hFFFFFFFE);
      lvl[0] <= 1'b1;
      tick(8);
      lvl[0] <= 1'b0;
      tick(8);
      `CHK(pulses, 3)
      wreg(12'h80D, 32'h2);
      wreg(12'h840, 32'h4);
      wreg(12'h824, 32'h0);
      wreg(12'h828, 32'h0);
      pin_is_input <= 32'h8;
      lvl[3] <= 1'b1;
      tick(3);
      lvl[3] <= 1'b0;
      tick(3);
      lvl[3] <= 1'b1;
      tick(40);
      `CHK(pulses, 4)
      lvl[3] <= 1'b0;
      tick(40);
      `CHK(pulses, 5)
      pin_is_input <= 32'h0;
      lvl[3] <= 1'b1;
      tick(8);
      lvl[3] <= 1'b0;
      tick(8);
      `CHK(pulses, 7)
      give_verdict;
   end
   initial begin
      #100us;
      num_errors++;
      give_verdict;
   end
endmodule
